// file: design/adsp_consts.svh
`ifndef ADSP_CONSTS_SVH
`define ADSP_CONSTS_SVH

// Word and command sizes.
`define ADSP_WORD_BITS 24
`define ADSP_WORD_LAST 5'h17
`define ADSP_CMD_LAST 5'h07
`define ADSP_CNT_ONE 5'h01
`define ADSP_CNT_ZERO 5'h00

// Command byte fields, first bit on the wire is the top bit.
`define ADSP_WEN_BIT 7
`define ADSP_RW_BIT 6
`define ADSP_SEL_HI 5
`define ADSP_SEL_LO 3

// Register indices and bank size.
`define ADSP_REG_STATUS 3'h0
`define ADSP_REG_DATA 3'h3
`define ADSP_REG_FIRST 1
`define ADSP_REG_COUNT 8

// Status word layout and reset values.
`define ADSP_STAT_RDY_BIT 7
`define ADSP_WORD_RESET 24'h000000
`define ADSP_CMD_RESET 7'h00

// Run of ones on the serial input that resets the port.
`define ADSP_ONES_LAST 6'h1f
`define ADSP_ONES_FULL 6'h20
`define ADSP_ONES_ZERO 6'h00
`define ADSP_ONES_ONE 6'h01

`endif

// file: design/adsp_pkg.sv
package adsp_pkg;

  // Serial port sequencer states.
  typedef enum logic [1:0] {
    ADSP_ST_CMD = 2'b00,
    ADSP_ST_RD = 2'b01,
    ADSP_ST_WR = 2'b10
  } adsp_state_t;

endpackage

// file: design/adsp_sync.sv
`timescale 1ns/1ps

module adsp_sync (
  input wire logic clk_in,   // Destination clock.
  input wire logic nrst_in,  // Asynchronous reset, active low.
  input wire logic d_in,     // Level from the other domain.
  output logic q_out         // Synchronised level.
);

  logic meta_q;

  // Two flip-flops; the first is read only by the second.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_q <= 1'b0;
      q_out <= 1'b0;
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end

endmodule

// file: design/adsp_port.sv
`timescale 1ns/1ps
`include "adsp_consts.svh"

module adsp_port (
  input wire logic CLOCK_IN,                          // System clock, 100 MHz.
  input wire logic NRST_IN,                           // Asynchronous reset, active low.
  input wire logic LINK_SCLK_IN,                      // Serial clock from the host.
  input wire logic LINK_CS_N_IN,                      // Chip select, active low.
  input wire logic LINK_DIN_IN,                       // Serial data input.
  input wire logic CONV_DONE_IN,                      // Conversion result ready, one-cycle pulse.
  input wire logic CONV_PREP_IN,                      // Result update is near, one-cycle pulse.
  input wire logic [`ADSP_WORD_BITS-1:0] CONV_DATA_IN, // Conversion result.
  output logic LINK_DOUT_OUT,                         // Serial data out, low-active ready.
  output logic LINK_DOUT_OE_OUT                       // Output enable of the data pin.
);

  logic rdy_n_q;
  logic [`ADSP_WORD_BITS-1:0] conv_word_q;
  logic conv_tog_q, conv_pend_q, conv_ack_sys;
  logic sel_sys, rd_tog_sys, rst_tog_sys;
  logic rd_tog_prev_q, rst_tog_prev_q;
  logic rd_edge, rst_edge;

  adsp_pkg::adsp_state_t state_q;
  logic [4:0] bit_cnt_q;
  logic [6:0] cmd_sh_q;
  logic [2:0] sel_q;
  logic [`ADSP_WORD_BITS-1:0] word_sh_q;
  logic [5:0] ones_q;
  logic rd_tog_q, rst_tog_q, conv_prev_q;
  logic conv_tog_link, rdy_n_link;
  logic dout_link_q, drv_rd_q;
  logic [7:0] cmd_full;
  logic ones_hit, wr_done, conv_edge, data_busy;
  logic [`ADSP_WORD_BITS-1:0] rd_word, status_word;
  logic [`ADSP_WORD_BITS-1:0] bank_q [0:`ADSP_REG_COUNT-1];

  // Crossings between the system and link domains.
  adsp_sync u_sync_cs (.clk_in(CLOCK_IN), .nrst_in(NRST_IN), .d_in(!LINK_CS_N_IN), .q_out(sel_sys));
  adsp_sync u_sync_rd (.clk_in(CLOCK_IN), .nrst_in(NRST_IN), .d_in(rd_tog_q), .q_out(rd_tog_sys));
  adsp_sync u_sync_rst (.clk_in(CLOCK_IN), .nrst_in(NRST_IN), .d_in(rst_tog_q), .q_out(rst_tog_sys));
  adsp_sync u_sync_conv (.clk_in(LINK_SCLK_IN), .nrst_in(NRST_IN), .d_in(conv_tog_q), .q_out(conv_tog_link));
  adsp_sync u_sync_rdy (.clk_in(LINK_SCLK_IN), .nrst_in(NRST_IN), .d_in(!rdy_n_q), .q_out(rdy_n_link));
  adsp_sync u_sync_ack (.clk_in(CLOCK_IN), .nrst_in(NRST_IN), .d_in(conv_prev_q), .q_out(conv_ack_sys));

  // Toggle edges become single-cycle events in the system domain.
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rd_tog_prev_q <= 1'b0;
      rst_tog_prev_q <= 1'b0;
    end else begin
      rd_tog_prev_q <= rd_tog_sys;
      rst_tog_prev_q <= rst_tog_sys;
    end
  end
  assign rd_edge = rd_tog_sys ^ rd_tog_prev_q;
  assign rst_edge = rst_tog_sys ^ rst_tog_prev_q;

  // Ready flag: a new result wins over any clearing event in the same cycle.
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rdy_n_q <= 1'b1;
    end else if (CONV_DONE_IN) begin
      rdy_n_q <= 1'b0;
    end else if (CONV_PREP_IN || rd_edge || rst_edge) begin
      rdy_n_q <= 1'b1;
    end
  end

  // Result word is held and announced by a toggle; a newer result waits on a flag until the link has answered.
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      conv_word_q <= `ADSP_WORD_RESET;
      conv_tog_q <= 1'b0;
      conv_pend_q <= 1'b0;
    end else begin
      conv_word_q <= CONV_DONE_IN ? CONV_DATA_IN : conv_word_q;
      conv_tog_q <= conv_tog_q ^ ((conv_tog_q == conv_ack_sys) && (CONV_DONE_IN || conv_pend_q));
      conv_pend_q <= (CONV_DONE_IN || conv_pend_q) && (conv_tog_q != conv_ack_sys);
    end
  end

  // Pin enable follows the synchronised chip select.
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      LINK_DOUT_OE_OUT <= 1'b0;
    end else begin
      LINK_DOUT_OE_OUT <= sel_sys;
    end
  end

  // During a read the pin carries data, otherwise the ready level.
  assign LINK_DOUT_OUT = drv_rd_q ? dout_link_q : rdy_n_q;

  // Decode helpers for the link sequencer.
  assign cmd_full = {cmd_sh_q, LINK_DIN_IN};
  assign ones_hit = LINK_DIN_IN && (ones_q == `ADSP_ONES_LAST);
  assign wr_done = !LINK_CS_N_IN && !ones_hit && (state_q == adsp_pkg::ADSP_ST_WR) &&
                   (bit_cnt_q == `ADSP_WORD_LAST);
  assign conv_edge = conv_tog_link ^ conv_prev_q;
  assign data_busy = (state_q == adsp_pkg::ADSP_ST_RD) && (sel_q == `ADSP_REG_DATA);

  // Word presented for a read; index 0 reads back the status.
  always_comb begin
    status_word = `ADSP_WORD_RESET;
    status_word[`ADSP_STAT_RDY_BIT] = rdy_n_link;
    if (cmd_full[`ADSP_SEL_HI:`ADSP_SEL_LO] == `ADSP_REG_STATUS) begin
      rd_word = status_word;
    end else begin
      rd_word = bank_q[cmd_full[`ADSP_SEL_HI:`ADSP_SEL_LO]];
    end
  end

  // Run of ones on the serial input, saturating once the reset length is seen.
  always_ff @(posedge LINK_SCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ones_q <= `ADSP_ONES_ZERO;
    end else if (!LINK_CS_N_IN) begin
      if (!LINK_DIN_IN) begin
        ones_q <= `ADSP_ONES_ZERO;
      end else if (ones_q != `ADSP_ONES_FULL) begin
        ones_q <= ones_q + `ADSP_ONES_ONE;
      end
    end
  end

  // Link sequencer: command byte, then one read or write word (none for a write to the status index), then back to the command wait.
  always_ff @(posedge LINK_SCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state_q <= adsp_pkg::ADSP_ST_CMD;
      bit_cnt_q <= `ADSP_CNT_ZERO;
      cmd_sh_q <= `ADSP_CMD_RESET;
      sel_q <= `ADSP_REG_STATUS;
      word_sh_q <= `ADSP_WORD_RESET;
      rd_tog_q <= 1'b0;
      rst_tog_q <= 1'b0;
    end else if (!LINK_CS_N_IN) begin
      if (ones_hit) begin
        state_q <= adsp_pkg::ADSP_ST_CMD;
        bit_cnt_q <= `ADSP_CNT_ZERO;
        cmd_sh_q <= `ADSP_CMD_RESET;
        rst_tog_q <= ~rst_tog_q;
      end else begin
        unique case (state_q)
          adsp_pkg::ADSP_ST_CMD: begin
            if (bit_cnt_q != `ADSP_CNT_ZERO || !LINK_DIN_IN) begin
              cmd_sh_q <= cmd_full[6:0];
              if (bit_cnt_q == `ADSP_CMD_LAST) begin
                bit_cnt_q <= `ADSP_CNT_ZERO;
                sel_q <= cmd_full[`ADSP_SEL_HI:`ADSP_SEL_LO];
                if (cmd_full[`ADSP_RW_BIT]) begin
                  state_q <= adsp_pkg::ADSP_ST_RD;
                  word_sh_q <= rd_word;
                end else if (cmd_full[`ADSP_SEL_HI:`ADSP_SEL_LO] != `ADSP_REG_STATUS) begin
                  state_q <= adsp_pkg::ADSP_ST_WR;
                end
              end else begin
                bit_cnt_q <= bit_cnt_q + `ADSP_CNT_ONE;
              end
            end
          end
          adsp_pkg::ADSP_ST_RD: begin
            if (bit_cnt_q == `ADSP_WORD_LAST) begin
              state_q <= adsp_pkg::ADSP_ST_CMD;
              bit_cnt_q <= `ADSP_CNT_ZERO;
              if (sel_q == `ADSP_REG_DATA) begin
                rd_tog_q <= ~rd_tog_q;
              end
            end else begin
              bit_cnt_q <= bit_cnt_q + `ADSP_CNT_ONE;
            end
          end
          adsp_pkg::ADSP_ST_WR: begin
            word_sh_q <= {word_sh_q[`ADSP_WORD_BITS-2:0], LINK_DIN_IN};
            if (bit_cnt_q == `ADSP_WORD_LAST) begin
              state_q <= adsp_pkg::ADSP_ST_CMD;
              bit_cnt_q <= `ADSP_CNT_ZERO;
            end else begin
              bit_cnt_q <= bit_cnt_q + `ADSP_CNT_ONE;
            end
          end
          default: begin
            state_q <= adsp_pkg::ADSP_ST_CMD;
          end
        endcase
      end
    end
  end

  // Remembers the last seen result toggle on the link side.
  always_ff @(posedge LINK_SCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      conv_prev_q <= 1'b0;
    end else if (!conv_edge || !data_busy) begin
      conv_prev_q <= conv_tog_link;
    end
  end

  // Register bank; the data entry takes results, the others above the status entry take host writes.
  assign bank_q[`ADSP_REG_STATUS] = `ADSP_WORD_RESET;
  for (genvar i = `ADSP_REG_FIRST; i < `ADSP_REG_COUNT; i++) begin : g_bank
    always_ff @(posedge LINK_SCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
        bank_q[i] <= `ADSP_WORD_RESET;
      end else if (!LINK_CS_N_IN && ones_hit) begin
        bank_q[i] <= `ADSP_WORD_RESET;
      end else if (i == `ADSP_REG_DATA) begin
        if (conv_edge && !data_busy) begin
          bank_q[i] <= conv_word_q;
        end
      end else if (wr_done && sel_q == i) begin
        bank_q[i] <= {word_sh_q[`ADSP_WORD_BITS-2:0], LINK_DIN_IN};
      end
    end
  end

  // Output bit changes on the falling edge so the host samples it rising.
  always_ff @(negedge LINK_SCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      dout_link_q <= 1'b1;
      drv_rd_q <= 1'b0;
    end else begin
      dout_link_q <= word_sh_q[`ADSP_WORD_LAST - bit_cnt_q];
      drv_rd_q <= !LINK_CS_N_IN && (state_q == adsp_pkg::ADSP_ST_RD);
    end
  end

  // Checks on the behaviour above.
  sequence cmd_read_s;
    !LINK_CS_N_IN && !ones_hit && state_q == adsp_pkg::ADSP_ST_CMD &&
      bit_cnt_q == `ADSP_CMD_LAST && cmd_full[`ADSP_RW_BIT];
  endsequence

  sequence read_last_s;
    !LINK_CS_N_IN && !ones_hit && state_q == adsp_pkg::ADSP_ST_RD && bit_cnt_q == `ADSP_WORD_LAST;
  endsequence

  AST_RDY_LOW: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
    CONV_DONE_IN |=> !rdy_n_q ##1 (!rdy_n_q || $past(CONV_PREP_IN) || $past(rd_edge) || $past(rst_edge)))
    else $error("ready not low after conversion");

  AST_RDY_HIGH: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
    (CONV_PREP_IN && !CONV_DONE_IN) |=> rdy_n_q)
    else $error("ready not high before update");

  AST_READ_LOAD: assert property (@(posedge LINK_SCLK_IN) disable iff (!NRST_IN)
    cmd_read_s |=> state_q == adsp_pkg::ADSP_ST_RD && bit_cnt_q == `ADSP_CNT_ZERO &&
      word_sh_q == $past(rd_word))
    else $error("read word not loaded after command");

  AST_OUT_FALL: assert property (@(negedge LINK_SCLK_IN) disable iff (!NRST_IN)
    (!LINK_CS_N_IN && state_q == adsp_pkg::ADSP_ST_RD) |=> drv_rd_q && LINK_DOUT_OUT == dout_link_q)
    else $error("data bit not driven on falling edge");

  AST_READ_END: assert property (@(posedge LINK_SCLK_IN) disable iff (!NRST_IN)
    read_last_s |=> state_q == adsp_pkg::ADSP_ST_CMD && bit_cnt_q == `ADSP_CNT_ZERO)
    else $error("no return to command wait after read");

  AST_SHIFT_IN: assert property (@(posedge LINK_SCLK_IN) disable iff (!NRST_IN)
    (!LINK_CS_N_IN && !ones_hit && state_q == adsp_pkg::ADSP_ST_WR) |=>
      word_sh_q == {$past(word_sh_q[`ADSP_WORD_BITS-2:0]), $past(LINK_DIN_IN)})
    else $error("input bit not shifted in");

  AST_WRITE_REG: assert property (@(posedge LINK_SCLK_IN) disable iff (!NRST_IN)
    (wr_done && sel_q != `ADSP_REG_DATA) |=> bank_q[$past(sel_q)] == word_sh_q)
    else $error("written word not stored in selected register");

  AST_ONES_RESET: assert property (@(posedge LINK_SCLK_IN) disable iff (!NRST_IN)
    (!LINK_CS_N_IN && ones_hit) |=> state_q == adsp_pkg::ADSP_ST_CMD && ones_q == `ADSP_ONES_FULL)
    else $error("thirty-two ones did not reset the port");

  AST_WEN_HOLD: assert property (@(posedge LINK_SCLK_IN) disable iff (!NRST_IN)
    (!LINK_CS_N_IN && LINK_DIN_IN && !ones_hit && state_q == adsp_pkg::ADSP_ST_CMD &&
      bit_cnt_q == `ADSP_CNT_ZERO) |=> bit_cnt_q == `ADSP_CNT_ZERO)
    else $error("command started on a high first bit");

  AST_CS_FREEZE: assert property (@(posedge LINK_SCLK_IN) disable iff (!NRST_IN)
    LINK_CS_N_IN |=> $stable(state_q) && $stable(word_sh_q) && $stable(cmd_sh_q) && $stable(bit_cnt_q))
    else $error("shift state moved while deselected");

endmodule

// file: sim/adsp_host.sv
`timescale 1ns/1ps

// Host-side serial master: it makes the serial clock, selects the port and samples the reply.
module adsp_host (
  output logic sclk_out,    // Serial clock, stands high between frames.
  output logic cs_n_out,    // Chip select, active low.
  output logic din_out,     // Serial data towards the port.
  input wire logic dout_in, // Serial data or ready level from the port.
  input wire logic oe_in    // Drive enable of the port's data pin.
);
  localparam time HALF = 32ns;
  int falls = 0;

  // Counts falling edges of the data pin, which the host may take as a result interrupt.
  always @(negedge dout_in) begin
    falls++;
  end

  // Lines idle with the clock high and the port deselected.
  initial begin
    sclk_out = 1'b1;
    cs_n_out = 1'b1;
    din_out = 1'b0;
  end

  // Shifts n bits out, top bit first, and collects the reply bit seen at each rising edge.
  // A bit seen while the port does not drive its pin is taken as unknown.
  task automatic shift(input int n, input logic [39:0] v, output logic [39:0] r);
    r = '0;
    for (int i = n - 1; i >= 0; i--) begin
      sclk_out = 1'b0;
      din_out = v[i];
      #HALF;
      sclk_out = 1'b1;
      r = {r[38:0], oe_in ? dout_in : 1'bx};
      #HALF;
    end
  endtask

  // One framed transfer; chip select is low around the n bits of v, whatever they hold.
  task automatic frame(input int n, input logic [39:0] v, output logic [39:0] r);
    cs_n_out = 1'b0;
    #100ns;
    shift(n, v, r);
    cs_n_out = 1'b1;
    din_out = ~din_out; // A released line must not keep showing its last level.
    #100ns;
  endtask

  // Clock pulses with the port deselected and the data line held high.
  task automatic idle_clocks(input int n);
    din_out = 1'b1;
    for (int i = 0; i < n; i++) begin
      sclk_out = 1'b0;
      #HALF;
      sclk_out = 1'b1;
      #HALF;
    end
  endtask

  // Holds the port selected for a run of transfers, as when chip select is tied low.
  task automatic hold_select(input logic on);
    cs_n_out = !on;
    #100ns;
  endtask
endmodule

// file: sim/test_adsp_port.sv
`timescale 1ns/1ps
`include "adsp_consts.svh"
`define TB_CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin n_fail++; \
  $display("MISMATCH %s expected %h seen %h", what, exp, got); end end

// Drives the port through a host model and judges conversion and register traffic.
module test_adsp_port;
  localparam logic [23:0] RESULT = 24'ha5c31e;
  logic clk = 1'b0;
  logic nrst_n = 1'b1;
  logic done = 1'b0;
  logic prep = 1'b0;
  logic [23:0] cdata = 24'h000000;
  logic sclk, cs_n, din, dout, oe;
  logic [39:0] rx;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;

  // System clock at 100 MHz.
  always #5 clk = ~clk;

  adsp_port dut (
    .CLOCK_IN(clk), .NRST_IN(nrst_n), .LINK_SCLK_IN(sclk), .LINK_CS_N_IN(cs_n), .LINK_DIN_IN(din),
    .CONV_DONE_IN(done), .CONV_PREP_IN(prep), .CONV_DATA_IN(cdata), .LINK_DOUT_OUT(dout),
    .LINK_DOUT_OE_OUT(oe)
  );
  adsp_host host (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din), .dout_in(dout), .oe_in(oe));

  // Cuts a hung run short and reports it as a failure.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  // A distinct word for each plain register.
  function automatic logic [23:0] word_of(input int s);
    return {4'h9, s[3:0], 16'h3c0f};
  endfunction

  // One-cycle conversion event: done with a result, or the warning of the next update.
  task automatic pulse_conv(input logic is_done, input logic [23:0] d);
    @(posedge clk);
    done <= is_done;
    prep <= ~is_done;
    cdata <= d;
    @(posedge clk);
    done <= 1'b0;
    prep <= 1'b0;
    #1;
  endtask

  // Command read of one register, reply in the last 24 bits.
  task automatic reg_read(input logic [2:0] sel, output logic [23:0] v);
    host.frame(32, {8'h00, 2'b01, sel, 3'b000, 24'h000000}, rx);
    v = rx[23:0];
  endtask

  // Command write of one register.
  task automatic reg_write(input logic [2:0] sel, input logic [23:0] v);
    host.frame(32, {8'h00, 2'b00, sel, 3'b000, v}, rx);
  endtask

  // Pin levels while reset is held.
  task automatic t_reset;
    `TB_CHK("dout in reset", 1'b1, dout)
    `TB_CHK("oe in reset", 1'b0, oe)
  endtask

  // Ready falls on a finished conversion and rises again before the next update.
  task automatic t_ready;
    pulse_conv(1'b1, 24'h123456);
    `TB_CHK("ready low", 1'b0, dout)
    `TB_CHK("ready falls", 1, host.falls)
    pulse_conv(1'b0, 24'h000000);
    `TB_CHK("ready high", 1'b1, dout)
  endtask

  // A fresh result shows in status, reads out top bit first, and the read clears ready.
  task automatic t_result;
    logic [23:0] v;
    pulse_conv(1'b1, RESULT);
    `TB_CHK("ready low again", 1'b0, dout)
    reg_read(`ADSP_REG_STATUS, v);
    `TB_CHK("status ready", 1'b1, v[`ADSP_STAT_RDY_BIT])
    reg_read(`ADSP_REG_DATA, v);
    `TB_CHK("result word", RESULT, v)
    reg_read(`ADSP_REG_STATUS, v);
    `TB_CHK("status after read", 1'b0, v[`ADSP_STAT_RDY_BIT])
  endtask

  // Back-to-back writes to every plain register, then each is read back.
  task automatic t_regs;
    logic [23:0] v;
    for (int s = 1; s < 8; s++) begin
      if (s != 3) reg_write(s[2:0], word_of(s));
    end
    for (int s = 1; s < 8; s++) begin
      if (s != 3) begin
        reg_read(s[2:0], v);
        `TB_CHK("register readback", word_of(s), v)
      end
    end
  endtask

  // Clock edges while deselected must not shift, not even a long run of ones.
  task automatic t_freeze;
    logic [23:0] v;
    host.idle_clocks(40);
    reg_read(3'h1, v);
    `TB_CHK("held through deselect", word_of(1), v)
  endtask

  // Thirty-two ones reset the port; the next command is obeyed at once.
  task automatic t_ones;
    logic [23:0] v;
    host.frame(32, 40'h00ffffffff, rx);
    reg_read(3'h2, v);
    `TB_CHK("cleared by ones", 24'h000000, v)
  endtask

  // A leading one before the command byte is skipped and the write still lands.
  task automatic t_wen;
    logic [23:0] v;
    host.frame(33, {7'h00, 1'b1, 8'h10, 24'h5a0c33}, rx);
    reg_read(3'h2, v);
    `TB_CHK("write after skipped bit", 24'h5a0c33, v)
  endtask

  // Chip select held low for a write and its read back, with no framing between them.
  task automatic t_three_wire;
    host.hold_select(1'b1);
    host.shift(32, {8'h00, 8'h30, 24'h0f1e2d}, rx);
    host.shift(32, {8'h00, 8'h70, 24'h000000}, rx);
    host.hold_select(1'b0);
    `TB_CHK("three-wire readback", 24'h0f1e2d, rx[23:0])
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict;
    $display("Comparisons: %0d, mismatches: %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence: reset for two cycles, then each scenario in turn.
  initial begin
    @(posedge clk);
    nrst_n <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    nrst_n <= 1'b1;
    t_ready();
    t_result();
    t_regs();
    t_freeze();
    t_ones();
    t_wen();
    t_three_wire();
    print_verdict();
  end
endmodule
